// ---- logic/dhc_debug_hold_control.sv ----
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module dhc_debug_hold_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,               // Power reset only
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Core and power mode status
    input  wire logic        core_halted_i,
    input  wire logic        sleep_mode_i,
    input  wire logic        deep_sleep_mode_i,
    input  wire logic        standby_mode_i,
    // Peripheral freeze outputs
    output logic             timer_zero_freeze_o,
    output logic             timer_one_freeze_o,
    output logic             timer_two_freeze_o,
    output logic             timer_three_freeze_o,
    output logic             timer_four_freeze_o,
    output logic             timer_five_freeze_o,
    output logic             timer_six_freeze_o,
    output logic             timer_seven_freeze_o,
    output logic             timer_eight_freeze_o,
    output logic             timer_nine_freeze_o,
    output logic             timer_ten_freeze_o,
    output logic             timer_eleven_freeze_o,
    output logic             timer_twelve_freeze_o,
    output logic             timer_thirteen_freeze_o,
    output logic             first_can_rx_freeze_o,
    output logic             second_can_rx_freeze_o,
    output logic             first_i2c_timeout_freeze_o,
    output logic             second_i2c_timeout_freeze_o,
    output logic             window_watchdog_freeze_o,
    output logic             free_watchdog_freeze_o,
    // Trace and low-power clock control
    output logic             trace_pin_allocate_o,
    output logic             keep_bus_clock_o,     // Bus clock not gated
    output logic             use_internal_rc_8mhz_clock_o, // Clocks from RC 8 MHz
    output logic             standby_exit_reset_o  // One-cycle system reset request
);
    import dhc_pkg::*;

    // ****************************************************************
    // Operating notes
    // ****************************************************************
    // The block is one software-owned control word plus gating.
    // Every freeze output is the control bit ANDed with the live
    // halt input; nothing about the halt is stored here.
    // Why not register the freeze outputs: a registered copy would
    // keep a timer frozen one cycle after the core resumes, and the
    // debugger would see a counter that lags the instruction stream.
    // The cost is a combinational path from core_halted_i to every
    // peripheral, so the halt source must itself be a flop.
    //
    // Bus timing, as seen by a classic master:
    //   edge 0: request sampled in idle, write lands, read data latched
    //   edge 1: ack sampled high, master takes data and lets go
    //   edge 2: slave back in idle, ack low again
    // A request still held at edge 1 is not taken twice, because the
    // slave only accepts new work from the idle state.
    //
    // Byte lanes are merged one byte at a time, so software may
    // update a single field group without a read-modify-write.
    // Reserved bits are masked on every write and read back as zero.
    // Limitation: a write to an unmapped offset is acked and dropped,
    // so software gets no error for a wrong address.
    //
    // Low-power keep bits act only while the matching mode is in
    // force; outside that mode they are stored but have no effect.
    // Sleep keeps the running bus clock, while deep sleep and
    // standby move the bus and system clocks to the RC source.
    // Leaving standby after the keep bit was seen raises a one-cycle
    // reset request for the system reset logic outside this block.
    //
    // Reset: rst_i is the power reset only. There is deliberately no
    // system reset input, so a debugger setup survives a system reset
    // and halt-after-reset sessions keep their freeze choices.
    //
    // Timer nine has a hold bit as well, wired like the others.

    // ****************************************************************
    // Control register and bus state
    // ****************************************************************
    logic [31:0] debug_freeze_control_r; // Software-owned control bits
    logic [31:0] ctrl_nxt;               // Value after a byte-lane write
    logic [31:0] freeze_w;               // Gated freeze vector
    dhc_bus_e    bus_state_r;            // Ack pacing
    logic        standby_keep_seen_r;    // Standby entered with keep set
    logic        standby_prev_r;         // Last sample of standby input
    logic        standby_reset_r;        // Registered reset request
    logic        bus_req;                // New request this cycle
    logic        wr_ctrl;                // Write hits the control word

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Lane merge used for each byte of a write
    // Unselected lanes keep their old value
    function automatic logic [31:0] dhc_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ****************************************************************
    // Request decode
    // ****************************************************************
    // Request only in idle, so ack drops the cycle after it was given
    // Address is compared in full; no aliasing of the control word
    assign bus_req = wb_cyc_i && wb_stb_i && (bus_state_r == DHC_IDLE);
    assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == DHC_OFS_CTRL);

    // Reserved bits are dropped, so a careless write cannot set them
    assign ctrl_nxt = dhc_merge(debug_freeze_control_r, wb_dat_i, wb_sel_i)
                      & DHC_CTRL_WMASK;

    // ****************************************************************
    // Bus slave: one wait state, ack is a one-cycle pulse
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_state_r <= DHC_IDLE;
        end else begin
            case (bus_state_r)
                DHC_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= DHC_ACK;
                    end
                end
                DHC_ACK: begin
                    bus_state_r <= DHC_IDLE;
                end
                default: begin
                    bus_state_r <= DHC_IDLE;
                end
            endcase
        end
    end

    assign wb_ack_o = (bus_state_r == DHC_ACK);

    // Ack decoded from the state flop, so it is glitch free

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Only bus writes touch it; no hardware event sets or clears bits
    // Power reset is the sole other way back to zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            debug_freeze_control_r <= DHC_CTRL_RESET;
        end else if (wr_ctrl) begin
            debug_freeze_control_r <= ctrl_nxt;
        end
    end

    // ****************************************************************
    // Read path
    // ****************************************************************
    // Read data latched with the request, held through ack
    // Status shows the live gated vector, useful to confirm a freeze
    // Data output keeps the last read value between reads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= DHC_RD_UNMAPPED;
        end else if (bus_req && !wb_we_i) begin
            case (wb_adr_i)
                DHC_OFS_ID:     wb_dat_o <= DHC_ID_VALUE;
                DHC_OFS_CTRL:   wb_dat_o <= debug_freeze_control_r;
                DHC_OFS_STATUS: wb_dat_o <= freeze_w;
                default:        wb_dat_o <= DHC_RD_UNMAPPED; // Unmapped reads zero
            endcase
        end
    end

    // ****************************************************************
    // Freeze gating
    // ****************************************************************
    dhc_freeze_gate u_gate (
        .ctrl_i        (debug_freeze_control_r),
        .core_halted_i (core_halted_i),
        .freeze_o      (freeze_w)
    );

    // Upper timer group
    assign timer_eight_freeze_o    = freeze_w[DHC_B_TIMER8];
    assign timer_thirteen_freeze_o = freeze_w[DHC_B_TIMER13];
    assign timer_twelve_freeze_o   = freeze_w[DHC_B_TIMER12];
    assign timer_eleven_freeze_o   = freeze_w[DHC_B_TIMER11];
    // Middle timer group
    assign timer_seven_freeze_o    = freeze_w[DHC_B_TIMER7];
    assign timer_six_freeze_o      = freeze_w[DHC_B_TIMER6];
    assign timer_five_freeze_o     = freeze_w[DHC_B_TIMER5];
    assign timer_four_freeze_o     = freeze_w[DHC_B_TIMER4];
    // Lower timer group, then timers nine and ten from the top bits
    assign timer_three_freeze_o    = freeze_w[DHC_B_TIMER3];
    assign timer_two_freeze_o      = freeze_w[DHC_B_TIMER2];
    assign timer_one_freeze_o      = freeze_w[DHC_B_TIMER1];
    assign timer_zero_freeze_o     = freeze_w[DHC_B_TIMER0];
    assign timer_nine_freeze_o     = freeze_w[DHC_B_TIMER9];
    assign timer_ten_freeze_o      = freeze_w[DHC_B_TIMER10];
    // Receive paths and serial timeouts
    // A frozen receiver drops frames; the debugger accepts that loss
    assign second_can_rx_freeze_o  = freeze_w[DHC_B_CAN_B];
    assign first_can_rx_freeze_o   = freeze_w[DHC_B_CAN_A];
    assign second_i2c_timeout_freeze_o = freeze_w[DHC_B_I2C_B];
    assign first_i2c_timeout_freeze_o  = freeze_w[DHC_B_I2C_A];
    // Watchdogs: without these a halted core would be reset
    assign window_watchdog_freeze_o = freeze_w[DHC_B_WWDG];
    assign free_watchdog_freeze_o   = freeze_w[DHC_B_FWDG];

    // ****************************************************************
    // Trace and low-power clock keep
    // ****************************************************************
    // Trace allocation is a plain level, independent of halt
    assign trace_pin_allocate_o = debug_freeze_control_r[DHC_B_TRACE];

    // Bus clock stays on in any mode whose keep bit is set
    assign keep_bus_clock_o =
        (sleep_mode_i      && debug_freeze_control_r[DHC_B_SLEEP])     ||
        (deep_sleep_mode_i && debug_freeze_control_r[DHC_B_DEEPSLEEP]) ||
        (standby_mode_i    && debug_freeze_control_r[DHC_B_STANDBY]);

    // Sleep keeps the running clock; the deeper modes swap to the RC source
    assign use_internal_rc_8mhz_clock_o =
        (deep_sleep_mode_i && debug_freeze_control_r[DHC_B_DEEPSLEEP]) ||
        (standby_mode_i    && debug_freeze_control_r[DHC_B_STANDBY]);

    // ****************************************************************
    // Standby exit reset request
    // ****************************************************************
    // Track standby entry with keep set, to request reset on exit
    // The request is one cycle; the reset logic outside must stretch it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            standby_prev_r      <= 1'b0;
            standby_keep_seen_r <= 1'b0;
            standby_reset_r     <= 1'b0;
        end else begin
            standby_prev_r  <= standby_mode_i;
            standby_reset_r <= 1'b0;
            if (standby_mode_i && debug_freeze_control_r[DHC_B_STANDBY]) begin
                standby_keep_seen_r <= 1'b1;
            end else if (standby_prev_r && !standby_mode_i) begin
                // Exit edge: pulse reset if standby was held
                standby_reset_r     <= standby_keep_seen_r;
                standby_keep_seen_r <= 1'b0;
            end
        end
    end

    assign standby_exit_reset_o = standby_reset_r;
endmodule
`default_nettype wire

// ---- inc/dhc_pkg.sv ----
`default_nettype none
package dhc_pkg;
    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0]  DHC_OFS_ID         = 8'h00; // Identity word, read only
    localparam logic [7:0]  DHC_OFS_CTRL       = 8'h04; // debug_freeze_control
    localparam logic [7:0]  DHC_OFS_STATUS     = 8'h08; // Live state of the hold outputs
    localparam logic [31:0] DHC_ID_VALUE       = 32'h0000_0D1C; // Arbitrary identity value
    localparam logic [31:0] DHC_CTRL_RESET     = 32'h0000_0000; // Power-on value
    // Writable bits; reserved 31, 24:22, 7:6 and 4:3 read as zero
    localparam logic [31:0] DHC_CTRL_WMASK     = 32'h7E3F_FF27;
    localparam logic [31:0] DHC_RD_UNMAPPED    = 32'h0000_0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DHC_B_TIMER10   = 30;
    localparam int DHC_B_TIMER9    = 29;
    localparam int DHC_B_TIMER8    = 28;
    localparam int DHC_B_TIMER13   = 27;
    localparam int DHC_B_TIMER12   = 26;
    localparam int DHC_B_TIMER11   = 25;
    localparam int DHC_B_CAN_B     = 21;
    localparam int DHC_B_TIMER7    = 20;
    localparam int DHC_B_TIMER6    = 19;
    localparam int DHC_B_TIMER5    = 18;
    localparam int DHC_B_TIMER4    = 17;
    localparam int DHC_B_I2C_B     = 16;
    localparam int DHC_B_I2C_A     = 15;
    localparam int DHC_B_CAN_A     = 14;
    localparam int DHC_B_TIMER3    = 13;
    localparam int DHC_B_TIMER2    = 12;
    localparam int DHC_B_TIMER1    = 11;
    localparam int DHC_B_TIMER0    = 10;
    localparam int DHC_B_WWDG      = 9;
    localparam int DHC_B_FWDG      = 8;
    localparam int DHC_B_TRACE     = 5;
    localparam int DHC_B_STANDBY   = 2;
    localparam int DHC_B_DEEPSLEEP = 1;
    localparam int DHC_B_SLEEP     = 0;

    // ****************************************************************
    // Bus slave states
    // ****************************************************************
    typedef enum logic [0:0] {
        DHC_IDLE = 1'b0,
        DHC_ACK  = 1'b1
    } dhc_bus_e;
endpackage
`default_nettype wire

// ---- logic/dhc_freeze_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Freeze gate: control bit qualified by the live halt input
// ****************************************************************
module dhc_freeze_gate (
    input  wire logic [31:0] ctrl_i,
    input  wire logic        core_halted_i,
    output logic      [31:0] freeze_o
);
    // Pure AND, so release follows the core resuming at once
    assign freeze_o = ctrl_i & {32{core_halted_i}};
endmodule
`default_nettype wire

// ---- tb/dhc_hold_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Checker: bus handshake, freeze gating, low-power outputs
// ****************************************************************
module dhc_hold_sva (
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire logic core_halted_i, sleep_mode_i, deep_sleep_mode_i, standby_mode_i,
    input wire logic timer_eight_freeze_o, first_can_rx_freeze_o, free_watchdog_freeze_o,
    input wire logic trace_pin_allocate_o, keep_bus_clock_o, standby_exit_reset_o
);
    logic wr_ack; // A write taking effect
    assign wr_ack = wb_ack_o && wb_we_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Slave answers exactly one cycle after a fresh request
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !$past(wb_ack_o)
        |=> wb_ack_o) else $error("ack missing after request");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    // Freeze never outlives the halt
    a_freeze_needs_halt: assert property (!core_halted_i |-> !(timer_eight_freeze_o ||
        first_can_rx_freeze_o || free_watchdog_freeze_o)) else $error("freeze without halt");
    // Control bits move only with a software write
    a_timer_eight_src: assert property ($changed(timer_eight_freeze_o) |->
        $changed(core_halted_i) || wr_ack) else $error("timer freeze moved alone");
    a_can_rx_src: assert property ($changed(first_can_rx_freeze_o) |->
        $changed(core_halted_i) || wr_ack) else $error("can freeze moved alone");
    a_free_wd_src: assert property ($changed(free_watchdog_freeze_o) |->
        $changed(core_halted_i) || wr_ack) else $error("watchdog freeze moved alone");
    a_trace_by_write: assert property ($changed(trace_pin_allocate_o) |-> wr_ack)
        else $error("trace moved alone");
    a_keep_needs_mode: assert property (keep_bus_clock_o |-> sleep_mode_i ||
        deep_sleep_mode_i || standby_mode_i) else $error("clock kept outside mode");
    a_exit_single: assert property (standby_exit_reset_o |=> !standby_exit_reset_o)
        else $error("exit reset too long");
    a_exit_after_fall: assert property (standby_exit_reset_o |-> !standby_mode_i &&
        ($past(standby_mode_i, 2) || $past(standby_mode_i, 3))) else $error("exit reset late");
endmodule
`default_nettype wire

// ---- tb/dhc_periph_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Halt source and one counter that a freeze input stops
module dhc_periph_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       halt_req_i,    // Debugger halt request
    input  wire logic       freeze_i,      // Freeze from the hold block
    output logic            core_halted_o,
    output logic      [7:0] count_o
);
    // Halt status lags the request by a cycle, as a real core would
    always_ff @(posedge clk_i) begin
        core_halted_o <= rst_i ? 1'b0 : halt_req_i;
    end
    // Counter stops only while frozen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
        end else if (!freeze_i) begin
            count_o <= count_o + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ---- tb/dhc_debug_hold_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module dhc_debug_hold_control_tb;
    import dhc_pkg::*;
    localparam logic [31:0] FM = 32'h7E3F_FF00; // Freeze bit positions
    typedef struct packed { logic [31:0] w; logic h; } dhc_row_s;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, halt = 1'b0;
    logic sl = 1'b0, ds = 1'b0, sb = 1'b0, ack, hal, keep, rc, trc, ex;
    logic [7:0] adr = 8'h00, cnt, c0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dq, q, fz;
    int err_total = 0, n_checks = 0, np;
    dhc_row_s rows [11] = '{'{32'h1000_0000, 1'b1}, '{32'h0E00_0000, 1'b1},
        '{32'h001E_0000, 1'b1}, '{32'h0000_3C00, 1'b1}, '{32'h0020_0000, 1'b1},
        '{32'h0000_4000, 1'b1}, '{32'h0001_8000, 1'b1}, '{32'h0000_0200, 1'b1},
        '{32'h0000_0100, 1'b1}, '{32'h4000_0000, 1'b1}, '{32'h7E3F_FF27, 1'b0}};
    always #12.5 clk_i = ~clk_i; // 40 MHz
    dhc_debug_hold_control u_dhc_debug_hold_control (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dq), .wb_ack_o(ack), .core_halted_i(hal),
        .sleep_mode_i(sl), .deep_sleep_mode_i(ds), .standby_mode_i(sb),
        .timer_zero_freeze_o(fz[10]), .timer_one_freeze_o(fz[11]), .timer_two_freeze_o(fz[12]),
        .timer_three_freeze_o(fz[13]), .timer_four_freeze_o(fz[17]),
        .timer_five_freeze_o(fz[18]), .timer_six_freeze_o(fz[19]),
        .timer_seven_freeze_o(fz[20]), .timer_eight_freeze_o(fz[28]),
        .timer_nine_freeze_o(fz[29]), .timer_ten_freeze_o(fz[30]),
        .timer_eleven_freeze_o(fz[25]), .timer_twelve_freeze_o(fz[26]),
        .timer_thirteen_freeze_o(fz[27]), .first_can_rx_freeze_o(fz[14]),
        .second_can_rx_freeze_o(fz[21]), .first_i2c_timeout_freeze_o(fz[15]),
        .second_i2c_timeout_freeze_o(fz[16]), .window_watchdog_freeze_o(fz[9]),
        .free_watchdog_freeze_o(fz[8]), .trace_pin_allocate_o(trc), .keep_bus_clock_o(keep),
        .use_internal_rc_8mhz_clock_o(rc), .standby_exit_reset_o(ex));
    dhc_periph_model u_dhc_periph_model (.clk_i(clk_i), .rst_i(rst_i), .halt_req_i(halt),
        .freeze_i(fz[8]), .core_halted_o(hal), .count_o(cnt));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Classic single cycle; ack is read at the edge before its update lands
    task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
        n = 0;
        do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
        q = dq;
        if (ack !== 1'b1) begin err_total++; report_and_stop(); end
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic settle; repeat (3) @(posedge clk_i); @(negedge clk_i); endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wbx(1'b0, DHC_OFS_CTRL, 32'h0); chk("ctrl reset", q, 32'h0000_0000);
        wbx(1'b0, DHC_OFS_ID, 32'h0); chk("id", q, DHC_ID_VALUE);
        wbx(1'b0, 8'h0C, 32'h0); chk("unmapped", q, DHC_RD_UNMAPPED);
        foreach (rows[i]) begin
            wbx(1'b1, DHC_OFS_CTRL, rows[i].w);
            halt <= rows[i].h;
            settle();
            chk("freeze", fz & FM, rows[i].h ? rows[i].w & FM : 32'h0);
            wbx(1'b0, DHC_OFS_CTRL, 32'h0); chk("ctrl", q, rows[i].w & DHC_CTRL_WMASK);
        end
        wbx(1'b1, DHC_OFS_CTRL, 32'h0000_0100); halt <= 1'b1; settle(); c0 = cnt;
        repeat (5) @(negedge clk_i); chk("count held", {24'h0, cnt}, {24'h0, c0});
        wbx(1'b0, DHC_OFS_STATUS, 32'h0); chk("status", q, 32'h0000_0100);
        halt <= 1'b0; settle(); c0 = cnt;
        repeat (5) @(negedge clk_i); chk("count runs", {24'h0, cnt}, {24'h0, c0 + 8'h05});
        wbx(1'b1, DHC_OFS_CTRL, 32'h0000_0007);
        for (int m = 0; m < 3; m++) begin
            @(posedge clk_i);
            sl <= (m == 0); ds <= (m == 1); sb <= (m == 2); settle();
            chk("clock keep", {30'h0, keep, rc}, {30'h0, 1'b1, m != 0});
        end
        @(posedge clk_i); sb <= 1'b0; np = 0;
        repeat (8) begin @(negedge clk_i); if (ex === 1'b1) np++; end
        chk("exit reset", np, 1);
        wbx(1'b1, DHC_OFS_CTRL, 32'h0000_0020); sl <= 1'b1; settle();
        chk("sleep off", {31'h0, keep}, 32'h0);
        chk("trace", {31'h0, trc}, 32'h1);
        @(posedge clk_i); rst_i <= 1'b1; repeat (2) @(posedge clk_i); rst_i <= 1'b0;
        wbx(1'b0, DHC_OFS_CTRL, 32'h0); chk("ctrl rerst", q, 32'h0000_0000);
        report_and_stop();
    end
endmodule
bind dhc_debug_hold_control dhc_hold_sva u_dhc_hold_sva (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .core_halted_i(core_halted_i), .sleep_mode_i(sleep_mode_i),
    .deep_sleep_mode_i(deep_sleep_mode_i), .standby_mode_i(standby_mode_i),
    .timer_eight_freeze_o(timer_eight_freeze_o), .first_can_rx_freeze_o(first_can_rx_freeze_o),
    .free_watchdog_freeze_o(free_watchdog_freeze_o), .trace_pin_allocate_o(trace_pin_allocate_o),
    .keep_bus_clock_o(keep_bus_clock_o), .standby_exit_reset_o(standby_exit_reset_o));
`default_nettype wire
